// ---- acfp_defs.svh ----
`ifndef ACFP_DEFS_SVH
`define ACFP_DEFS_SVH

// frame layout
`define ACFP_FRAME_BITS       256
`define ACFP_TAG_BITS         16
`define ACFP_SLOT_BITS        20
`define ACFP_CMD_LAST         8'h37
`define ACFP_FRAME_LAST       8'hFF
`define ACFP_CODEC_ID_PRIMARY 2'h0

// register indices carried in slot 1
`define ACFP_IDX_RESET        7'h00
`define ACFP_IDX_PD           7'h26
`define ACFP_IDX_FEAT         7'h6A

// power-down control/status
`define ACFP_PD_RESET         16'h0000
`define ACFP_PD_WMASK         16'hFFF0
`define ACFP_PD_LINK_BIT      12

// feature control one
`define ACFP_FEAT_RESET       16'h0000
`define ACFP_FEAT_WAKE_BIT    0

// timing
`define ACFP_CLK_NS           100
`define ACFP_WARM_NS          1000
`define ACFP_WARM_CYC         ((`ACFP_WARM_NS + `ACFP_CLK_NS - 1) / `ACFP_CLK_NS)
`define ACFP_SETTLE_CYC       16

`endif

// ---- acfp_pkg.sv ----
package acfp_pkg;

   typedef enum logic [4:0] {
      ACFP_ST_SETTLE  = 5'h01,
      ACFP_ST_RUN     = 5'h02,
      ACFP_ST_HALT    = 5'h04,
      ACFP_ST_WARM_HI = 5'h08,
      ACFP_ST_WARM_LO = 5'h10
   } acfp_pwr_state_t;

   // tag, slot 1 and slot 2 of an output frame, first bit at the top
   typedef struct packed {
      logic [15:0] tag;
      logic [19:0] slot1;
      logic [19:0] slot2;
   } acfp_cmd_t;

   // whole input frame, first bit sent at the top
   typedef struct packed {
      logic [15:0]  tag;
      logic [19:0]  slot1;
      logic [19:0]  slot2;
      logic [19:0]  slot3;
      logic [19:0]  slot4;
      logic [139:0] unused;
      logic [19:0]  slot12;
   } acfp_in_frame_t;

   typedef struct packed {
      logic        valid;
      logic [19:0] left;
      logic [19:0] right;
   } acfp_rec_t;

endpackage

// ---- acfp_sync2.sv ----
`timescale 1ns/100ps
module acfp_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   if (WIDTH < 1) begin : g_chk
      $error("acfp_sync2: WIDTH must be at least 1");
   end

   // first stage feeds only the second
   always_ff @(posedge clk) begin
      meta <= d;
      q    <= meta;
   end
endmodule

// ---- acfp_tx_shift.sv ----
`timescale 1ns/100ps
module acfp_tx_shift #(
   parameter int WIDTH = 256
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] word,
   output logic                  next_bit
);
   logic [WIDTH-1:0] shreg;

   if (WIDTH < 2) begin : g_chk
      $error("acfp_tx_shift: WIDTH must be at least 2");
   end

   assign next_bit = load ? word[WIDTH-1] : shreg[WIDTH-1];

   // zeros shift in behind the frame
   always_ff @(posedge clk) begin
      if (rst) begin
         shreg <= '0;
      end else if (load) begin
         shreg <= {word[WIDTH-2:0], 1'b0};
      end else begin
         shreg <= {shreg[WIDTH-2:0], 1'b0};
      end
   end
endmodule

// ---- acfp_link_top.sv ----
`timescale 1ns/100ps
`include "acfp_defs.svh"

module acfp_link_top #(
   parameter int unsigned SETTLE_CYCLES = `ACFP_SETTLE_CYC
) (
   input  wire logic              clock,
   input  wire logic              srst,
   input  wire logic              link_clk,
   input  wire logic              sync,
   input  wire logic              sdata_out,
   input  wire logic              wake_event,
   input  wire logic [3:0]        subsection_ready,
   input  wire logic              play_req_left,
   input  wire logic              play_req_right,
   input  wire acfp_pkg::acfp_rec_t rec_sample,
   output logic                   bit_clk_run,
   output logic                   sdata_in,
   output logic                   codec_ready,
   output logic [15:0]            power_down_ctrl
);
   import acfp_pkg::*;

   if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_chk
      $error("acfp_link_top: SETTLE_CYCLES must be 1 to 65535");
   end

   if (`ACFP_FRAME_BITS != $bits(acfp_in_frame_t)) begin : g_chk_frame
      $error("acfp_link_top: input frame layout does not fill a frame");
   end

   if (`ACFP_CMD_LAST != $bits(acfp_cmd_t) - 1) begin : g_chk_cmd
      $error("acfp_link_top: command decode point does not match command layout");
   end

   if (`ACFP_WARM_CYC < 2 || `ACFP_WARM_CYC > 65535) begin : g_chk_warm
      $error("acfp_link_top: warm reset length does not fit the counter");
   end

   // ------------------------------------------------------------------
   // system clock domain: power state, warm reset detection
   // ------------------------------------------------------------------
   acfp_pwr_state_t state;
   acfp_pwr_state_t next_state;
   logic [15:0]     cnt;
   logic [15:0]     next_cnt;
   logic            run;
   logic            sync_y;
   logic            halt_y;
   logic            link_halt;

   acfp_sync2 #(.WIDTH(2)) u_sync_sys (
      .clk (clock),
      .d   ({sync, link_halt}),
      .q   ({sync_y, halt_y})
   );

   wire settle_done = (cnt == 16'(SETTLE_CYCLES - 1));
   wire warm_long   = (cnt == 16'(`ACFP_WARM_CYC - 1));
   wire next_run    = (next_state == ACFP_ST_SETTLE) || (next_state == ACFP_ST_RUN);
   wire next_ready  = (next_state == ACFP_ST_RUN);

   always_comb begin
      next_state = state;
      case (state)
         ACFP_ST_SETTLE: begin
            if (halt_y) begin
               next_state = ACFP_ST_HALT;
            end else if (settle_done) begin
               next_state = ACFP_ST_RUN;
            end
         end
         ACFP_ST_RUN: begin
            if (halt_y) begin
               next_state = ACFP_ST_HALT;
            end
         end
         ACFP_ST_HALT: begin
            if (sync_y) begin
               next_state = ACFP_ST_WARM_HI;
            end
         end
         ACFP_ST_WARM_HI: begin
            if (!sync_y) begin
               next_state = ACFP_ST_HALT;
            end else if (warm_long) begin
               next_state = ACFP_ST_WARM_LO;
            end
         end
         ACFP_ST_WARM_LO: begin
            if (!sync_y) begin
               next_state = ACFP_ST_SETTLE;
            end
         end
         default: begin
            next_state = ACFP_ST_SETTLE;
         end
      endcase
   end

   assign next_cnt = (next_state != state) ? 16'h0000 : cnt + 16'h0001;

   // cold reset restarts the clock with ready low
   always_ff @(posedge clock) begin
      if (srst) begin
         state       <= ACFP_ST_SETTLE;
         cnt         <= 16'h0000;
         run         <= 1'b1;
         codec_ready <= 1'b0;
      end else begin
         state       <= next_state;
         cnt         <= next_cnt;
         run         <= next_run;
         codec_ready <= next_ready;
      end
   end

   // ------------------------------------------------------------------
   // link clock domain
   // ------------------------------------------------------------------
   logic lrst;
   logic run_l;
   logic ready_l;
   logic wake_l;

   // srst reaches the link side two link clocks late; hold reset long enough
   acfp_sync2 #(.WIDTH(4)) u_sync_link (
      .clk (link_clk),
      .d   ({srst, run, codec_ready, wake_event}),
      .q   ({lrst, run_l, ready_l, wake_l})
   );

   logic [15:0] pd_reg;
   logic [15:0] feat_reg;
   logic        sync_s;
   logic        frame_open;
   logic [7:0]  rx_cnt;
   logic [55:0] rx_shift;
   logic        start_n;
   logic        rd_tgl;
   logic        rd_ack;
   logic [6:0]  rd_idx;
   logic [15:0] rd_data;
   logic        wake_drive;
   logic        wake_saw_hi;
   logic        tx_bit;
   acfp_cmd_t   cmd;
   acfp_in_frame_t frame;

   // halt takes effect at once, before the system side notices
   wire link_active = run_l & ~link_halt;
   wire wake_en     = feat_reg[`ACFP_FEAT_WAKE_BIT];

   // frame start: sync seen high on a falling edge after being low
   wire frame_start = link_active & sync & ~sync_s;

   wire [55:0] next_rx = {rx_shift[54:0], sdata_out};
   wire cmd_edge = link_active & frame_open & ~frame_start & (rx_cnt == `ACFP_CMD_LAST);
   assign cmd = acfp_cmd_t'(next_rx);

   wire cmd_ok = cmd.tag[15] & cmd.tag[14] & (cmd.tag[1:0] == `ACFP_CODEC_ID_PRIMARY);
   wire is_rd  = cmd_edge & cmd_ok & cmd.slot1[19];
   wire is_wr  = cmd_edge & cmd_ok & ~cmd.slot1[19] & cmd.tag[13];
   wire [6:0]  cmd_idx = cmd.slot1[18:12];
   wire [15:0] cmd_wd  = cmd.slot2[19:4];

   wire wr_reset = is_wr & (cmd_idx == `ACFP_IDX_RESET);
   wire wr_pd    = is_wr & (cmd_idx == `ACFP_IDX_PD);
   wire wr_feat  = is_wr & (cmd_idx == `ACFP_IDX_FEAT);
   wire pd_link  = wr_pd & cmd_wd[`ACFP_PD_LINK_BIT];

   // odd and unknown indices read as zero
   wire [15:0] pd_read = {pd_reg[15:4], subsection_ready};
   wire [15:0] rd_mux  = (cmd_idx == `ACFP_IDX_PD)   ? pd_read  :
                         (cmd_idx == `ACFP_IDX_FEAT) ? feat_reg : 16'h0000;

   // frame edge detect
   always_ff @(negedge link_clk) begin
      sync_s  <= sync;
      start_n <= frame_start;
   end

   // receive side samples on falling edges
   always_ff @(negedge link_clk) begin
      if (lrst || !link_active) begin
         rx_cnt     <= 8'h00;
         rx_shift   <= '0;
         frame_open <= 1'b0;
      end else if (frame_start) begin
         rx_cnt     <= 8'h00;
         frame_open <= 1'b1;
      end else begin
         rx_shift <= next_rx;
         rx_cnt   <= rx_cnt + 8'h01;
         if (rx_cnt == `ACFP_FRAME_LAST) begin
            frame_open <= 1'b0;
         end
      end
   end

   // registers: kept through every power-down state
   always_ff @(negedge link_clk) begin
      if (lrst || wr_reset) begin
         pd_reg   <= `ACFP_PD_RESET;
         feat_reg <= `ACFP_FEAT_RESET;
      end else begin
         if (wr_pd) begin
            pd_reg <= cmd_wd & `ACFP_PD_WMASK;
         end
         if (wr_feat) begin
            feat_reg <= cmd_wd;
         end
      end
   end

   assign power_down_ctrl = pd_reg;

   // read reply captured now, sent in the next frame
   always_ff @(negedge link_clk) begin
      if (lrst) begin
         rd_tgl  <= 1'b0;
         rd_idx  <= 7'h00;
         rd_data <= 16'h0000;
      end else if (is_rd) begin
         rd_tgl  <= ~rd_tgl;
         rd_idx  <= cmd_idx;
         rd_data <= rd_mux;
      end
   end

   // halt on decode, released once system side has stopped the link
   always_ff @(negedge link_clk) begin
      if (lrst || !run_l) begin
         link_halt <= 1'b0;
      end else if (pd_link) begin
         link_halt <= 1'b1;
      end
   end

   // wake signal on data line while halted, until sync goes high then low
   always_ff @(negedge link_clk) begin
      if (lrst) begin
         wake_drive  <= 1'b0;
         wake_saw_hi <= 1'b0;
      end else if (wake_drive) begin
         if (sync) begin
            wake_saw_hi <= 1'b1;
         end else if (wake_saw_hi) begin
            wake_drive  <= 1'b0;
            wake_saw_hi <= 1'b0;
         end
      end else if (!run_l && wake_en && wake_l) begin
         wake_drive <= 1'b1;
      end
   end

   // input frame assembly
   wire resp_now = (rd_tgl != rd_ack);

   wire        rec_valid   = rec_sample.valid;
   wire [6:0]  echo_idx    = resp_now ? rd_idx : 7'h00;
   wire [1:0]  slot_req_n  = {~play_req_left, ~play_req_right};
   wire [19:0] status_addr = {1'b0, echo_idx, slot_req_n, 10'h000};
   wire [19:0] status_data = resp_now ? {rd_data, 4'h0} : 20'h00000;
   wire [19:0] rec_left    = rec_valid ? rec_sample.left : 20'h00000;
   wire [19:0] rec_right   = rec_valid ? rec_sample.right : 20'h00000;
   wire        gpio_int    = wake_en & wake_l;

   always_comb begin
      frame         = '0;
      frame.tag[15] = ready_l;
      frame.tag[14] = resp_now;
      frame.tag[13] = resp_now;
      frame.tag[12] = rec_valid;
      frame.tag[11] = rec_valid;
      frame.tag[3]  = wake_en;
      frame.slot1   = status_addr;
      frame.slot2   = status_data;
      frame.slot3   = rec_left;
      frame.slot4   = rec_right;
      frame.slot12  = {19'h00000, gpio_int};
   end

   acfp_tx_shift #(.WIDTH(`ACFP_FRAME_BITS)) u_tx (
      .clk      (link_clk),
      .rst      (lrst),
      .load     (start_n),
      .word     (frame),
      .next_bit (tx_bit)
   );

   // read reply counts as sent once its frame is loaded
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         rd_ack <= 1'b0;
      end else if (start_n) begin
         rd_ack <= rd_tgl;
      end
   end

   // transmit side changes on rising edges
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         sdata_in    <= 1'b0;
         bit_clk_run <= 1'b0;
      end else begin
         sdata_in    <= link_active ? tx_bit : wake_drive;
         bit_clk_run <= link_active;
      end
   end

endmodule

// ---- acfp_link_asserts.sv ----
`timescale 1ns/100ps
module acfp_link_asserts #(
   parameter int unsigned SETTLE_CYCLES = 16
) (
   input wire logic        clock,
   input wire logic        srst,
   input wire logic        link_clk,
   input wire logic        sync,
   input wire logic        bit_clk_run,
   input wire logic        sdata_in,
   input wire logic        codec_ready,
   input wire logic [15:0] power_down_ctrl
);
   logic [8:0] pos;
   logic       t13;
   logic [7:0] rel;

   // bit position of the input frame being sampled, 1 = ready flag
   always_ff @(posedge link_clk) begin
      if (srst || !bit_clk_run) pos <= 9'h000;
      else if ($rose(sync)) pos <= 9'h001;
      else if (pos != 9'h000 && pos < 9'h12C) pos <= pos + 9'h001;
   end
   always_ff @(posedge link_clk) begin
      if (pos == 9'h003) t13 <= sdata_in;
   end
   always_ff @(posedge clock) begin
      if (srst) rel <= 8'h00;
      else if (rel != 8'hFF) rel <= rel + 8'h01;
   end

   sequence s_start;
      $rose(sync) && bit_clk_run;
   endsequence
   property p_quiet(lo, hi);
      @(posedge link_clk) disable iff (srst) (pos >= lo && pos <= hi) |-> !sdata_in;
   endproperty

   a_tag_unused_zero: assert property (p_quiet(6, 12))
      else $error("unused tag bit set");
   a_tag_low_zero: assert property (p_quiet(14, 16))
      else $error("low tag bits set");
   a_slot1_msb_zero: assert property (p_quiet(17, 17))
      else $error("status address msb set");
   a_slot1_stuff_zero: assert property (p_quiet(27, 36))
      else $error("unused request bit set");
   a_slot2_tail_zero: assert property (p_quiet(53, 56))
      else $error("status data tail set");
   a_mid_slots_zero: assert property (p_quiet(97, 236))
      else $error("slots 5 to 11 not zero");
   a_slot12_pins_zero: assert property (p_quiet(237, 255))
      else $error("slot 12 pin bits set");
   a_slot2_invalid: assert property (@(posedge link_clk) disable iff (srst)
      (pos >= 37 && pos <= 52 && !t13) |-> !sdata_in)
      else $error("untagged status data not zero");
   a_ready_tag: assert property (@(posedge link_clk) disable iff (srst)
      s_start ##0 (codec_ready && $past(codec_ready, 40)) |=> sdata_in)
      else $error("ready flag missing in tag");
   a_halt_data_low: assert property (@(posedge link_clk) disable iff (srst)
      $rose(power_down_ctrl[12]) |-> ##[0:2] (!bit_clk_run && !sdata_in))
      else $error("link not halted after power down");
   a_ready_settle: assert property (@(posedge clock) disable iff (srst)
      codec_ready |-> rel >= SETTLE_CYCLES - 1)
      else $error("ready before settle time");
endmodule

bind acfp_link_top acfp_link_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_asserts (.clock, .srst, .link_clk,
   .sync, .bit_clk_run, .sdata_in, .codec_ready, .power_down_ctrl);

// ---- acfp_ctrl_model.sv ----
`timescale 1ns/100ps
module acfp_ctrl_model (
   input  wire logic                link_clk,
   input  wire logic                bit_clk_run,
   input  wire logic                start,
   input  wire logic                warm,
   input  wire acfp_pkg::acfp_cmd_t cmd,
   input  wire logic                sdata_in,
   output logic                     sync,
   output logic                     sdata_out,
   output logic                     busy,
   output acfp_pkg::acfp_in_frame_t rx
);
   import acfp_pkg::*;
   logic [8:0] cnt = 9'h000;
   logic       fsync = 1'h0;
   acfp_cmd_t  sh = '0;

   initial {sdata_out, busy, rx} = '0;
   assign sync = fsync | warm;

   always @(posedge link_clk) begin
      if (!bit_clk_run) begin
         busy <= 1'h0;
         fsync <= 1'h0;
         sdata_out <= 1'h0;
      end else if (!busy) begin
         if (start) begin
            busy <= 1'h1;
            fsync <= 1'h1;
            cnt <= 9'h000;
            sh <= cmd;
         end
      end else begin
         cnt <= cnt + 9'h001;
         if (cnt == 9'h00F) fsync <= 1'h0;
         sdata_out <= (cnt < 9'h038) ? sh[55 - cnt] : 1'h0;
         if (cnt == 9'h100) busy <= 1'h0;
      end
   end

   always @(negedge link_clk) begin
      if (bit_clk_run && busy && cnt != 9'h000) rx[256 - cnt] <= sdata_in;
   end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
   import acfp_pkg::*;
   logic           clock = 1'h0;
   logic           link_clk = 1'h0;
   logic           srst = 1'h1;
   logic           wake_event = 1'h0;
   logic           warm = 1'h0;
   logic           start = 1'h0;
   logic           play_req_left = 1'h1;
   logic           play_req_right = 1'h0;
   logic [3:0]     subsection_ready = 4'hA;
   acfp_rec_t      rec_sample = {1'h1, 20'hABCDE, 20'h12345};
   acfp_cmd_t      cmd = '0;
   acfp_in_frame_t rx;
   logic           sync, sdata_out, bit_clk_run, sdata_in, codec_ready, busy;
   logic [15:0]    power_down_ctrl;
   int             num_errors = 0;
   int             tests_run = 0;

   initial forever #50 clock = ~clock;
   initial begin
      #1.7;
      forever #3 link_clk = ~link_clk;
   end

   acfp_link_top #(.SETTLE_CYCLES(4)) i_dut (.clock, .srst, .link_clk, .sync, .sdata_out, .wake_event,
      .subsection_ready, .play_req_left, .play_req_right, .rec_sample, .bit_clk_run, .sdata_in,
      .codec_ready, .power_down_ctrl);
   acfp_ctrl_model i_ctrl (.link_clk, .bit_clk_run, .start, .warm, .cmd, .sdata_in, .sync, .sdata_out,
      .busy, .rx);

   task automatic close_out;
      if (num_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [255:0] got, input logic [255:0] want);
      tests_run++;
      if (got !== want) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   // one output frame, waits for the model to finish it
   task automatic frame(input logic [15:0] tag, input logic [6:0] idx, input logic rd, input logic [15:0] d);
      @(negedge clock);
      cmd = {tag, rd, idx, 12'h000, rd ? 20'h00000 : {d, 4'h0}};
      start = 1'h1;
      repeat (5) if (!busy) @(negedge clock);
      start = 1'h0;
      repeat (40) if (busy) @(negedge clock);
      if (busy) num_errors++;
   endtask

   task automatic rd(input logic [6:0] idx);
      frame(16'hC000, idx, 1'h1, 16'h0000);
      frame(16'h8000, 7'h00, 1'h0, 16'h0000);
   endtask

   function automatic acfp_in_frame_t reply(input logic [6:0] idx, input logic [15:0] d, input logic we);
      reply = {5'h1F, 7'h00, we, 3'h0, 1'h0, idx, ~play_req_left, ~play_req_right, 10'h000, d, 4'h0,
               rec_sample.left, rec_sample.right, 140'h0, 20'h00000};
   endfunction

   initial begin
      repeat (3000) @(posedge clock);
      num_errors++;
      close_out;
   end

   initial begin
      repeat (10) @(negedge clock);
      srst = 1'h0;
      repeat (40) if (!codec_ready) @(negedge clock);
      chk(power_down_ctrl, 16'h0000);
      rd(7'h26);
      chk(rx, reply(7'h26, 16'h000A, 1'h0));
      frame(16'hE000, 7'h6A, 1'h0, 16'h0001);
      frame(16'h8000, 7'h00, 1'h0, 16'h0000);
      chk(rx.tag[14:13], 2'h0);
      rd(7'h6A);
      chk(rx, reply(7'h6A, 16'h0001, 1'h1));
      frame(16'hE001, 7'h6A, 1'h0, 16'h0000);
      rd(7'h6A);
      chk(rx, reply(7'h6A, 16'h0001, 1'h1));
      rd(7'h27);
      chk(rx, reply(7'h27, 16'h0000, 1'h1));
      frame(16'hE000, 7'h26, 1'h0, 16'h1000);
      chk({bit_clk_run, sdata_in, power_down_ctrl}, {2'h0, 16'h1000});
      repeat (70) @(negedge clock);
      wake_event = 1'h1;
      repeat (2) @(negedge clock);
      chk(sdata_in, 1'h1);
      warm = 1'h1;
      repeat (12) @(negedge clock);
      chk(bit_clk_run, 1'h0);
      warm = 1'h0;
      wake_event = 1'h0;
      repeat (40) if (!codec_ready) @(negedge clock);
      rd(7'h26);
      chk(rx, reply(7'h26, 16'h100A, 1'h1));
      frame(16'hE000, 7'h00, 1'h0, 16'h0000);
      rd(7'h6A);
      chk(rx, reply(7'h6A, 16'h0000, 1'h0));
      chk(power_down_ctrl, 16'h0000);
      close_out;
   end
endmodule
